// ---- hdl/nba_datapath.sv ----
// Purpose: accumulator and carry flag for add, add-with-carry and AND
// Assumes: decoder presents one instruction word per valid cycle; RAM
//          returns the pointed nibble combinationally in the same cycle
// Notes:   every operation completes at the edge that takes it
//          checks at the bottom follow each rule, not the alu expression
`default_nettype none
module nba_datapath (
    input  wire logic                                sys_clk,
    input  wire logic                                resetn,
    input  wire logic                                instr_valid,
    input  wire logic [nba_pkg::NBA_INSTR_W-1:0]     instr_code,
    input  wire logic [nba_pkg::NBA_DATA_W-1:0]      pointed_ram_nibble,
    input  wire logic [nba_pkg::NBA_DATA_W-1:0]      data_pointer,
    input  wire logic                                acc_load,
    input  wire logic [nba_pkg::NBA_DATA_W-1:0]      acc_load_value,
    input  wire logic                                carry_load,
    input  wire logic                                carry_load_value,
    output logic                                     op_hit,
    output logic      [nba_pkg::NBA_DATA_W-1:0]      acc_ff,
    output logic                                     carry_flag_ff,
    output logic                                     op_done_ff,
    output logic                                     skip_ff,
    output logic                                     ram_write_en,
    output logic      [nba_pkg::NBA_DATA_W-1:0]      data_pointer_out
);
    nba_pkg::nba_op_t                  op;
    logic [nba_pkg::NBA_DATA_W-1:0]    alu_result;
    logic                              alu_carry;
    logic [nba_pkg::NBA_DATA_W-1:0]    nxt_acc;
    logic                              nxt_carry;

    // decode only while the decoder presents a word
    assign op = instr_valid ? nba_pkg::nba_decode(instr_code)
                            : nba_pkg::NBA_OP_NONE;
    assign op_hit = (op != nba_pkg::NBA_OP_NONE);

    // the datapath never writes RAM nor moves the pointer
    assign ram_write_en     = 1'b0;
    assign data_pointer_out = data_pointer;

    nba_alu i_nba_alu (
        .op        (op),
        .acc_in    (acc_ff),
        .mem_in    (pointed_ram_nibble),
        .carry_in  (carry_flag_ff),
        .result    (alu_result),
        .carry_out (alu_carry)
    );

    // a datapath operation wins over a load in the same cycle
    always_comb begin
        nxt_acc   = acc_ff;
        nxt_carry = carry_flag_ff;
        if (op_hit) begin
            nxt_acc   = alu_result;
            nxt_carry = alu_carry;
        end else begin
            if (acc_load) begin
                nxt_acc = acc_load_value;
            end
            if (carry_load) begin
                nxt_carry = carry_load_value;
            end
        end
    end

    // accumulator register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc_ff <= nba_pkg::NBA_ACC_RST;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // carry flag register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            carry_flag_ff <= nba_pkg::NBA_CARRY_RST;
        end else begin
            carry_flag_ff <= nxt_carry;
        end
    end

    // completion pulse registered at the taking edge; never a skip
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            op_done_ff <= 1'b0;
            skip_ff    <= 1'b0;
        end else begin
            op_done_ff <= op_hit;
            skip_ff    <= 1'b0;
        end
    end

    // issue sequences of each operation, and the idle sequence with no word and no load
    sequence seq_add;
        instr_valid && (instr_code == nba_pkg::NBA_CODE_ADD_MEM);
    endsequence

    sequence seq_adc;
        instr_valid && (instr_code == nba_pkg::NBA_CODE_ADD_MEM_C);
    endsequence

    sequence seq_and;
        instr_valid && (instr_code == nba_pkg::NBA_CODE_AND_MEM);
    endsequence

    sequence seq_idle;
        !instr_valid && !acc_load && !carry_load;
    endsequence

    AST_ADD_SUM: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_add |=> acc_ff == 4'($past(acc_ff) + $past(pointed_ram_nibble)))
        else $error("add memory result wrong");

    AST_ADD_KEEPS_CARRY: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_add |=> $stable(carry_flag_ff))
        else $error("add memory changed carry");

    AST_ADC_SUM: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_adc |=> {carry_flag_ff, acc_ff} ==
            5'({1'b0, $past(acc_ff)} + {1'b0, $past(pointed_ram_nibble)}
               + {4'h0, $past(carry_flag_ff)}))
        else $error("add with carry sum wrong");

    AST_ADC_CARRY_SET: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_adc ##0 (5'({1'b0, acc_ff} + {1'b0, pointed_ram_nibble}
                         + {4'h0, carry_flag_ff}) > 5'h0f)
        |=> carry_flag_ff)
        else $error("carry out not captured");

    AST_ONE_CYCLE_DONE: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (seq_adc or seq_and or seq_add) |=> op_done_ff && !skip_ff)
        else $error("operation did not complete in one cycle");

    AST_AND_KEEPS_CARRY: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_and |=> $stable(carry_flag_ff) && op_done_ff)
        else $error("and changed carry");

    AST_AND_RESULT: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_and |=> acc_ff == ($past(acc_ff) & $past(pointed_ram_nibble)))
        else $error("and result wrong");

    AST_NO_SIDE_EFFECT: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_idle |=> $stable(acc_ff) && $stable(carry_flag_ff)
                     && !ram_write_en && !op_done_ff)
        else $error("state changed without an operation");

    // rule-level sum of the add-with-carry, used only by the checks
    logic [nba_pkg::NBA_SUM_W-1:0] chk_adc_sum;
    logic                          chk_adc_cout;
    assign chk_adc_sum  = {1'b0, acc_ff} + {1'b0, pointed_ram_nibble}
                        + {{nba_pkg::NBA_DATA_W{1'b0}}, carry_flag_ff};
    assign chk_adc_cout = chk_adc_sum[nba_pkg::NBA_CARRY_BIT];

    // add-with-carry issue whose sum stays below the carry bit
    sequence seq_adc_no_carry;
        seq_adc ##0 !chk_adc_cout;
    endsequence

    // valid word that is none of the three codes, no load beside it
    sequence seq_refused;
        instr_valid && !acc_load && !carry_load
        && (instr_code != nba_pkg::NBA_CODE_ADD_MEM)
        && (instr_code != nba_pkg::NBA_CODE_ADD_MEM_C)
        && (instr_code != nba_pkg::NBA_CODE_AND_MEM);
    endsequence

    // decode, carry and side-effect checks
    AST_ADC_CARRY_CLEAR: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_adc_no_carry |=> !carry_flag_ff)
        else $error("carry flag left set without carry out");

    AST_ADC_CARRY_OUT: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_adc |=> carry_flag_ff == $past(chk_adc_cout))
        else $error("carry flag differs from carry out");

    AST_HIT_ON_CODES: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (seq_adc or seq_and or seq_add) |-> op_hit)
        else $error("operation code not recognised");

    AST_NO_HIT_IDLE: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !instr_valid |-> !op_hit)
        else $error("hit raised without a valid word");

    AST_REFUSED_CODE: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        seq_refused |=> $stable(acc_ff) && $stable(carry_flag_ff)
                        && !op_done_ff)
        else $error("unknown code changed state");

    AST_DONE_ONLY_AFTER_OP: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !instr_valid |=> !op_done_ff)
        else $error("done without an operation");

    AST_CARRY_ONLY_ADC: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !(instr_valid && (instr_code == nba_pkg::NBA_CODE_ADD_MEM_C))
        && !carry_load |=> $stable(carry_flag_ff))
        else $error("carry changed outside add with carry");
endmodule
`default_nettype wire

// ---- hdl/nba_pkg.sv ----
// Purpose: constants and types shared by the nibble add and logic datapath
// Assumes: 10-bit instruction words, 4-bit accumulator and RAM nibbles
// Notes:   decoded operations are one-hot so a decode slip shows as a bad value
`default_nettype none
package nba_pkg;
    localparam int unsigned NBA_DATA_W  = 4;
    localparam int unsigned NBA_INSTR_W = 10;
    localparam int unsigned NBA_SUM_W   = NBA_DATA_W + 1;

    // instruction codes of the three datapath operations
    localparam logic [NBA_INSTR_W-1:0] NBA_CODE_ADD_MEM   = 10'h00a;
    localparam logic [NBA_INSTR_W-1:0] NBA_CODE_ADD_MEM_C = 10'h00b;
    localparam logic [NBA_INSTR_W-1:0] NBA_CODE_AND_MEM   = 10'h018;

    // reset values of the architectural state
    localparam logic [NBA_DATA_W-1:0] NBA_ACC_RST   = 4'h0;
    localparam logic                  NBA_CARRY_RST = 1'b0;

    // position of the carry out within the 5-bit sum
    localparam int unsigned NBA_CARRY_BIT = NBA_DATA_W;

    // decoded operation, one-hot
    typedef enum logic [3:0] {
        NBA_OP_NONE        = 4'h1,
        NBA_OP_ADD_MEM     = 4'h2,
        NBA_OP_ADD_MEM_C   = 4'h4,
        NBA_OP_AND_MEM     = 4'h8
    } nba_op_t;

    // maps an instruction word to its datapath operation
    function automatic nba_op_t nba_decode(
        input logic [NBA_INSTR_W-1:0] code
    );
        nba_op_t op;
        op = NBA_OP_NONE;
        case (code)
            NBA_CODE_ADD_MEM:   op = NBA_OP_ADD_MEM;
            NBA_CODE_ADD_MEM_C: op = NBA_OP_ADD_MEM_C;
            NBA_CODE_AND_MEM:   op = NBA_OP_AND_MEM;
            default:            op = NBA_OP_NONE;
        endcase
        return op;
    endfunction
endpackage
`default_nettype wire

// ---- hdl/nba_alu.sv ----
// Purpose: combinational nibble adder and AND unit
// Assumes: op is one-hot from the package decoder
// Notes:   result and carry are only meaningful for the three operations
`default_nettype none
module nba_alu (
    input  wire nba_pkg::nba_op_t                op,
    input  wire logic [nba_pkg::NBA_DATA_W-1:0] acc_in,
    input  wire logic [nba_pkg::NBA_DATA_W-1:0] mem_in,
    input  wire logic                           carry_in,
    output logic      [nba_pkg::NBA_DATA_W-1:0] result,
    output logic                                carry_out
);
    logic [nba_pkg::NBA_SUM_W-1:0] sum;
    logic                          cin_term;

    // carry enters the sum only for the add-with-carry form
    assign cin_term = (op == nba_pkg::NBA_OP_ADD_MEM_C) ? carry_in
                                                        : 1'b0;

    // five-bit sum keeps the carry out of bit 3
    assign sum = {1'b0, acc_in} + {1'b0, mem_in}
               + {{nba_pkg::NBA_DATA_W{1'b0}}, cin_term};

    // result selection per operation
    always_comb begin
        result    = acc_in;
        carry_out = carry_in;
        case (op)
            nba_pkg::NBA_OP_ADD_MEM: begin
                result = sum[nba_pkg::NBA_DATA_W-1:0];
            end
            nba_pkg::NBA_OP_ADD_MEM_C: begin
                result    = sum[nba_pkg::NBA_DATA_W-1:0];
                carry_out = sum[nba_pkg::NBA_CARRY_BIT];
            end
            nba_pkg::NBA_OP_AND_MEM: begin
                result = acc_in & mem_in;
            end
            default: begin
                result    = acc_in;
                carry_out = carry_in;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- verif/nba_ram_model.sv ----
// Purpose: RAM behind the datapath, read at the data pointer
// Assumes: bench fills it before use
// Notes:   read is combinational; datapath has no path to write it
`default_nettype none
module nba_ram_model (
    input  wire logic       sys_clk,
    input  wire logic       fill_en,
    input  wire logic [3:0] fill_addr,
    input  wire logic [3:0] fill_data,
    input  wire logic [3:0] data_pointer,
    output logic      [3:0] pointed_ram_nibble
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] mem_ff [16];
    // bench fill port only
    always_ff @(posedge sys_clk) begin
        if (fill_en) begin
            mem_ff[fill_addr] <= fill_data;
        end
    end
    // nibble at the pointer, same cycle
    assign pointed_ram_nibble = mem_ff[data_pointer];
endmodule
`default_nettype wire

// ---- verif/nibble_add_and_alu_tb_top.sv ----
// Purpose: self-checking bench for the nibble datapath
// Assumes: ram cell i holds i xor 9
// Notes:   expected acc and carry are tracked in e_acc and e_cf
`default_nettype none
module nibble_add_and_alu_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, resetn = 0, vld = 0, ald = 0, cld = 0, cv = 0;
    logic fen = 0, hit, cf, dn, sk, we;
    logic [9:0] code = 0;
    logic [3:0] ptr = 0, alv = 0, fa = 0, fd = 0, m, acc, dpo, e_acc;
    logic e_cf;
    int fails = 0, checks_done = 0;
    nba_ram_model i_nba_ram_model (.sys_clk(sys_clk), .fill_en(fen),
        .fill_addr(fa), .fill_data(fd), .data_pointer(ptr),
        .pointed_ram_nibble(m));
    nba_datapath i_nba_datapath (.sys_clk(sys_clk), .resetn(resetn),
        .instr_valid(vld), .instr_code(code), .pointed_ram_nibble(m),
        .data_pointer(ptr), .acc_load(ald), .acc_load_value(alv),
        .carry_load(cld), .carry_load_value(cv), .op_hit(hit),
        .acc_ff(acc), .carry_flag_ff(cf), .op_done_ff(dn), .skip_ff(sk),
        .ram_write_en(we), .data_pointer_out(dpo));
    // 250 MHz clock
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [4:0] s, e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one instruction word, judged one cycle later
    task automatic op(input logic [9:0] c, input logic [3:0] p, input h);
        logic [3:0] n;
        n = p ^ 4'h9;
        vld = 1;
        code = c;
        ptr = p;
        case (c)
            nba_pkg::NBA_CODE_ADD_MEM: e_acc = e_acc + n;
            nba_pkg::NBA_CODE_ADD_MEM_C:
                {e_cf, e_acc} = {1'b0, e_acc} + {1'b0, n} + {4'h0, e_cf};
            nba_pkg::NBA_CODE_AND_MEM: e_acc = e_acc & n;
            default: ;
        endcase
        #1 chk("hit", hit, h);
        chk("ptr", dpo, p);
        @(posedge sys_clk);
        #1 chk("acc", acc, e_acc);
        chk("carry", cf, e_cf);
        chk("done", dn, h);
        chk("skip", sk, 0);
        chk("ram we", we, 0);
    endtask
    task automatic load(input logic [3:0] a, input logic c);
        vld = 0;
        ald = 1;
        alv = a;
        cld = 1;
        cv = c;
        @(posedge sys_clk);
        #1 ald = 0;
        cld = 0;
        e_acc = a;
        e_cf = c;
        chk("load", {cf, acc}, {c, a});
    endtask
    task automatic t_add();
        load(4'hf, 1);
        op(nba_pkg::NBA_CODE_ADD_MEM, 4'h8, 1);
        load(4'hf, 0);
        op(nba_pkg::NBA_CODE_ADD_MEM, 4'h8, 1);
        load(4'h3, 0);
        op(nba_pkg::NBA_CODE_ADD_MEM, 4'h0, 1);
        $display("add test done");
    endtask
    task automatic t_adc();
        load(4'h7, 1);
        for (int i = 0; i < 16; i++) begin
            op(nba_pkg::NBA_CODE_ADD_MEM_C, i[3:0], 1);
        end
        $display("add carry test done");
    endtask
    task automatic t_and();
        load(4'hf, 1);
        for (int i = 15; i >= 0; i--) begin
            op(nba_pkg::NBA_CODE_AND_MEM, i[3:0], 1);
        end
        $display("and test done");
    endtask
    task automatic t_refuse();
        load(4'h6, 1);
        op(10'h00c, 4'h1, 0);
        op(10'h019, 4'h2, 0);
        ald = 1;
        alv = 4'h5;
        cld = 1;
        cv = 0;
        op(nba_pkg::NBA_CODE_ADD_MEM_C, 4'h4, 1);
        ald = 0;
        cld = 0;
        vld = 0;
        #1 chk("idle hit", hit, 0);
        @(posedge sys_clk);
        #1 chk("idle done", dn, 0);
        chk("idle acc", acc, e_acc);
        chk("idle carry", cf, e_cf);
        $display("refuse test done");
    endtask
    // mid-run reset clears state; first word right after release
    task automatic t_reset();
        load(4'h9, 1);
        resetn = 0;
        #1 chk("async clear", {cf, acc}, 5'h00);
        chk("async done", {sk, dn}, 0);
        @(posedge sys_clk);
        #1 resetn = 1;
        e_acc = nba_pkg::NBA_ACC_RST;
        e_cf = nba_pkg::NBA_CARRY_RST;
        op(nba_pkg::NBA_CODE_ADD_MEM_C, 4'h6, 1);
        op(nba_pkg::NBA_CODE_ADD_MEM_C, 4'h0, 1);
        $display("reset test done");
    endtask
    // reset for two cycles, fill ram, run scenarios
    initial begin
        #100000 fails++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 chk("rst", {cf, acc}, 5'h00);
        chk("rst done", {sk, dn}, 0);
        resetn = 1;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            #1 fen = 1;
            fa = i[3:0];
            fd = i[3:0] ^ 4'h9;
        end
        @(posedge sys_clk);
        #1 fen = 0;
        t_add();
        t_adc();
        t_and();
        t_refuse();
        t_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
